// *** hw/asi_tx_ctrl.sv ***
// audio serial transmit output control with register slave and bus error handling
// Behaviour
// - last bit drives a full bit period, or half then releases, per control bit 7.
// - keeper code 0 keeps keeper off, code 1 keeps it on.
// - keeper code 2 on one period, code 3 one and half, during last bit.
// - five bit start delay moves first MSB later by 0 to 31 bit clocks.
// - delay counts from slot 0 in TDM, from left and right slot 0 otherwise.
// - both data outputs follow the same drive, keeper and delay settings.
// - chain bit picks shared bus when clear, daisy chain when set.
// - bus error detection is on while its bit is zero, off when one.
// - resume bit zero resumes after error clears; one waits for host reconfiguration.
// - mix selection zero means no input mixing; only then is chaining allowed.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module asi_tx_ctrl
    import asi_tx_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus write
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // register bus read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // serial link
    input wire logic bclk,
    input wire logic fsync,
    input wire logic [1:0] asi_format,
    // channel data
    input wire logic [WORD_BITS-1:0] tx_word_pri,
    input wire logic [WORD_BITS-1:0] tx_word_sec,
    // data outputs
    output logic pri_dout,
    output logic pri_dout_oen,
    output logic pri_keeper_en,
    output logic sec_dout,
    output logic sec_dout_oen,
    output logic sec_keeper_en,
    // status
    output logic daisy_chain,
    output logic rec_power_on,
    output logic irq
);
    function automatic logic [5:0] word_idx(input logic [ADDR_W-1:0] a);
        word_idx = a[ADDR_W-1:2];
    endfunction

    function automatic logic is_mapped(input logic [5:0] i);
        is_mapped = (i == IDX_CFG1) || (i == IDX_CFG2) || (i == IDX_MIX) ||
                    (i == IDX_STAT) || (i == IDX_MASK) || (i == IDX_STATE);
    endfunction

    // ============================================================
    // link sampling
    logic b_s1_reg, b_s2_reg, b_d_reg, f_s1_reg, f_s2_reg, fs_at_reg;
    logic b_s1_next, b_s2_next, b_d_next, f_s1_next, f_s2_next, fs_at_next;
    logic bclk_rise, bclk_fall, frame_l, frame_r, frame_start, lead;

    assign bclk_rise = b_s2_reg & ~b_d_reg;
    assign bclk_fall = ~b_s2_reg & b_d_reg;
    assign frame_l = bclk_rise & f_s2_reg & ~fs_at_reg;
    assign frame_r = bclk_rise & ~f_s2_reg & fs_at_reg & (asi_format != FMT_TDM);
    assign frame_start = frame_l | frame_r;
    assign lead = (asi_format == FMT_I2S);

    always_comb begin
        b_s1_next = bclk;
        b_s2_next = b_s1_reg;
        b_d_next = b_s2_reg;
        f_s1_next = fsync;
        f_s2_next = f_s1_reg;
        fs_at_next = bclk_rise ? f_s2_reg : fs_at_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            b_s1_reg <= 1'b0;
            b_s2_reg <= 1'b0;
            b_d_reg <= 1'b0;
            f_s1_reg <= 1'b0;
            f_s2_reg <= 1'b0;
            fs_at_reg <= 1'b0;
        end else begin
            b_s1_reg <= b_s1_next;
            b_s2_reg <= b_s2_next;
            b_d_reg <= b_d_next;
            f_s1_reg <= f_s1_next;
            f_s2_reg <= f_s2_next;
            fs_at_reg <= fs_at_next;
        end
    end

    // ============================================================
    // register bus
    logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic [7:0] w_data_reg, w_data_next;
    logic w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic aw_take, w_take, do_wr, wr_lane;
    logic [5:0] wr_idx, rd_idx;
    logic [7:0] wr_byte;
    logic [7:0] cfg1_reg, cfg2_reg, mix_reg;
    logic [STAT_W-1:0] stat_reg, mask_reg;
    logic halted_reg;

    assign awready = ~aw_held_reg & ~bvalid_reg;
    assign wready = ~w_held_reg & ~bvalid_reg;
    assign arready = ~rvalid_reg;
    assign aw_take = awvalid & awready;
    assign w_take = wvalid & wready;
    assign do_wr = (aw_held_reg | aw_take) & (w_held_reg | w_take);
    assign wr_idx = word_idx(aw_held_reg ? aw_addr_reg : awaddr);
    assign wr_byte = w_held_reg ? w_data_reg : wdata[7:0];
    assign wr_lane = w_held_reg ? w_strb_reg : wstrb[0];
    assign rd_idx = word_idx(araddr);

    always_comb begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next = w_held_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg & ~bready;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg & ~rready;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (aw_take) begin
            aw_held_next = 1'b1;
            aw_addr_next = awaddr;
        end
        if (w_take) begin
            w_held_next = 1'b1;
            w_data_next = wdata[7:0];
            w_strb_next = wstrb[0];
        end
        if (do_wr) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
        end
        if (arvalid && arready) begin
            rvalid_next = 1'b1;
            rresp_next = is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
            rdata_next = '0;
            if (rd_idx == IDX_CFG1) begin
                rdata_next = DATA_W'(cfg1_reg);
            end else if (rd_idx == IDX_CFG2) begin
                rdata_next = DATA_W'(cfg2_reg);
            end else if (rd_idx == IDX_MIX) begin
                rdata_next = DATA_W'(mix_reg);
            end else if (rd_idx == IDX_STAT) begin
                rdata_next = DATA_W'(stat_reg);
            end else if (rd_idx == IDX_MASK) begin
                rdata_next = DATA_W'(mask_reg);
            end else if (rd_idx == IDX_STATE) begin
                rdata_next = DATA_W'({daisy_chain, halted_reg});
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_held_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_strb_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
        end else begin
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg <= w_held_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;

    // ============================================================
    // configuration, frame check and error handling
    logic [7:0] cfg1_next, cfg2_next, mix_next;
    logic [STAT_W-1:0] stat_next, mask_next, stat_set, stat_clr;
    logic [LEN_W-1:0] len_reg, len_next, last_len_reg, last_len_next;
    logic have_len_reg, have_len_next, halted_next;
    logic cfg_wr, match_evt, err_evt, wr_en;

    assign wr_en = do_wr & wr_lane;
    assign cfg_wr = wr_en & ((wr_idx == IDX_CFG1) | (wr_idx == IDX_CFG2) | (wr_idx == IDX_MIX));
    assign match_evt = frame_l & have_len_reg & (len_reg == last_len_reg);
    assign err_evt = frame_l & have_len_reg & (len_reg != last_len_reg) &
                     ~cfg2_reg[ERR_OFF_BIT] & ~halted_reg;
    assign daisy_chain = cfg2_reg[DAISY_BIT] & (mix_reg[MIX_HI:MIX_LO] == MIX_NONE);

    always_comb begin
        cfg1_next = cfg1_reg;
        cfg2_next = cfg2_reg;
        mix_next = mix_reg;
        mask_next = mask_reg;
        stat_clr = '0;
        if (wr_en && wr_idx == IDX_CFG1) begin
            cfg1_next = (wr_byte & CFG1_WMASK) | (CFG1_RST & ~CFG1_WMASK);
        end else if (wr_en && wr_idx == IDX_CFG2) begin
            cfg2_next = (wr_byte & CFG2_WMASK) | (CFG2_RST & ~CFG2_WMASK);
        end else if (wr_en && wr_idx == IDX_MIX) begin
            mix_next = (wr_byte & MIX_WMASK) | (MIX_RST & ~MIX_WMASK);
        end else if (wr_en && wr_idx == IDX_STAT) begin
            stat_clr = wr_byte[STAT_W-1:0];
        end else if (wr_en && wr_idx == IDX_MASK) begin
            mask_next = wr_byte[STAT_W-1:0];
        end
        len_next = len_reg;
        last_len_next = last_len_reg;
        have_len_next = have_len_reg;
        if (frame_l) begin
            len_next = LEN_W'(1);
            last_len_next = len_reg;
            have_len_next = (len_reg != '0);
        end else if (bclk_rise && len_reg != '1 && len_reg != '0) begin
            len_next = len_reg + LEN_W'(1);
        end
        halted_next = halted_reg;
        if (err_evt) begin
            halted_next = 1'b1;
        end else if (halted_reg && !cfg2_reg[RESUME_OFF_BIT] && match_evt) begin
            halted_next = 1'b0;
        end else if (halted_reg && cfg2_reg[RESUME_OFF_BIT] && cfg_wr) begin
            halted_next = 1'b0;
        end
        stat_set = '0;
        stat_set[ST_ERR] = err_evt;
        stat_set[ST_RESUME] = halted_reg & ~halted_next;
        stat_set[ST_DAISY_REJ] = cfg2_reg[DAISY_BIT] & ~daisy_chain;
        stat_next = (stat_reg & ~stat_clr) | stat_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg1_reg <= CFG1_RST;
            cfg2_reg <= CFG2_RST;
            mix_reg <= MIX_RST;
            stat_reg <= STAT_RST;
            mask_reg <= MASK_RST;
            len_reg <= '0;
            last_len_reg <= '0;
            have_len_reg <= 1'b0;
            halted_reg <= 1'b0;
        end else begin
            cfg1_reg <= cfg1_next;
            cfg2_reg <= cfg2_next;
            mix_reg <= mix_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            len_reg <= len_next;
            last_len_reg <= last_len_next;
            have_len_reg <= have_len_next;
            halted_reg <= halted_next;
        end
    end

    assign rec_power_on = ~halted_reg;
    assign irq = |(stat_reg & mask_reg);

    // ============================================================
    // data outputs, same settings on both lanes
    asi_tx_lane u_pri (
        .aclk(aclk),
        .aresetn(aresetn),
        .bclk_rise(bclk_rise),
        .bclk_fall(bclk_fall),
        .frame_start(frame_start),
        .run(~halted_reg),
        .lead(lead),
        .offset(cfg1_reg[OFS_HI:0]),
        .lsb_half(cfg1_reg[LSB_HALF_BIT]),
        .keeper_mode(cfg1_reg[KEEP_HI:KEEP_LO]),
        .word(tx_word_pri),
        .dout(pri_dout),
        .dout_oen(pri_dout_oen),
        .keeper_on(pri_keeper_en)
    );

    asi_tx_lane u_sec (
        .aclk(aclk),
        .aresetn(aresetn),
        .bclk_rise(bclk_rise),
        .bclk_fall(bclk_fall),
        .frame_start(frame_start),
        .run(~halted_reg),
        .lead(lead),
        .offset(cfg1_reg[OFS_HI:0]),
        .lsb_half(cfg1_reg[LSB_HALF_BIT]),
        .keeper_mode(cfg1_reg[KEEP_HI:KEEP_LO]),
        .word(tx_word_sec),
        .dout(sec_dout),
        .dout_oen(sec_dout_oen),
        .keeper_on(sec_keeper_en)
    );

    // ============================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_halt;
        err_evt ##1 halted_reg;
    endsequence
    property p_halt;
        s_halt |=> pri_dout_oen && sec_dout_oen && !rec_power_on;
    endproperty
    a_halt: assert property (p_halt) else $error("bus error did not halt outputs");

    property p_err_off;
        (cfg2_reg[ERR_OFF_BIT] && !halted_reg) |=> !halted_reg;
    endproperty
    a_err_off: assert property (p_err_off) else $error("halt while detection disabled");

    property p_hold;
        (halted_reg && cfg2_reg[RESUME_OFF_BIT] && !cfg_wr) |=> halted_reg;
    endproperty
    a_hold: assert property (p_hold) else $error("resumed without host write");

    property p_auto;
        (halted_reg && !cfg2_reg[RESUME_OFF_BIT] && match_evt) |=> !halted_reg ##1 rec_power_on;
    endproperty
    a_auto: assert property (p_auto) else $error("no automatic resume");

    property p_same;
        pri_dout_oen == sec_dout_oen && pri_keeper_en == sec_keeper_en;
    endproperty
    a_same: assert property (p_same) else $error("lanes differ in timing");

    property p_daisy;
        (mix_reg[MIX_HI:MIX_LO] != MIX_NONE) |-> !daisy_chain;
    endproperty
    a_daisy: assert property (p_daisy) else $error("chain active with mixing");

    property p_right;
        (bclk_rise && !f_s2_reg && fs_at_reg && asi_format == FMT_TDM) |-> !frame_start;
    endproperty
    a_right: assert property (p_right) else $error("right slot start in tdm");

    property p_irq;
        (err_evt && mask_reg[ST_ERR]) |=> irq && stat_reg[ST_ERR];
    endproperty
    a_irq: assert property (p_irq) else $error("error not flagged");
endmodule

// *** hw/asi_tx_lane.sv ***
// one serial data output: start delay, shifting, last bit drive and keeper
`timescale 1ns/1ps
module asi_tx_lane
    import asi_tx_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link timing
    input wire logic bclk_rise,
    input wire logic bclk_fall,
    input wire logic frame_start,
    input wire logic run,
    input wire logic lead,
    // settings
    input wire logic [OFS_HI:0] offset,
    input wire logic lsb_half,
    input wire logic [1:0] keeper_mode,
    // data
    input wire logic [WORD_BITS-1:0] word,
    output logic dout,
    output logic dout_oen,
    output logic keeper_on
);
    typedef enum logic [1:0] {L_IDLE, L_WAIT, L_SHIFT} lane_state_e;
    lane_state_e st_reg, st_next;
    logic [5:0] dly_reg, dly_next;
    logic [4:0] bits_reg, bits_next;
    logic [WORD_BITS-1:0] sh_reg, sh_next;
    logic dout_reg, dout_next;
    logic drv_reg, drv_next;
    logic [1:0] kh_reg, kh_next;

    // ============================================================
    // next state
    always_comb begin
        st_next = st_reg;
        dly_next = dly_reg;
        bits_next = bits_reg;
        sh_next = sh_reg;
        dout_next = dout_reg;
        drv_next = drv_reg;
        kh_next = kh_reg;
        if (kh_reg != 2'h0 && (bclk_rise || bclk_fall)) begin
            kh_next = kh_reg - 2'h1;
        end
        if (!run) begin
            st_next = L_IDLE;
            drv_next = 1'b0;
            kh_next = 2'h0;
        end else if (frame_start) begin
            st_next = L_WAIT;
            dly_next = 6'(offset) + 6'(lead);
            sh_next = word;
        end else begin
            case (st_reg)
                L_WAIT: begin
                    if (bclk_fall) begin
                        if (dly_reg == 6'h00) begin
                            dout_next = sh_reg[WORD_BITS-1];
                            sh_next = {sh_reg[WORD_BITS-2:0], 1'b0};
                            bits_next = 5'(WORD_BITS - 1);
                            drv_next = 1'b1;
                            st_next = L_SHIFT;
                        end else begin
                            dly_next = dly_reg - 6'h01;
                        end
                    end
                end
                L_SHIFT: begin
                    if (bclk_fall) begin
                        if (bits_reg == 5'h00) begin
                            drv_next = 1'b0;
                            st_next = L_IDLE;
                        end else begin
                            dout_next = sh_reg[WORD_BITS-1];
                            sh_next = {sh_reg[WORD_BITS-2:0], 1'b0};
                            bits_next = bits_reg - 5'h01;
                            if (bits_reg == 5'h01) begin
                                if (keeper_mode == KEEP_LSB1) begin
                                    kh_next = KH_ONE;
                                end else if (keeper_mode == KEEP_LSB15) begin
                                    kh_next = KH_ONE_HALF;
                                end
                            end
                        end
                    end else if (bclk_rise && bits_reg == 5'h00 && lsb_half) begin
                        drv_next = 1'b0;
                    end
                end
                default: begin
                    st_next = L_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= L_IDLE;
            dly_reg <= 6'h00;
            bits_reg <= 5'h00;
            sh_reg <= '0;
            dout_reg <= 1'b0;
            drv_reg <= 1'b0;
            kh_reg <= 2'h0;
        end else begin
            st_reg <= st_next;
            dly_reg <= dly_next;
            bits_reg <= bits_next;
            sh_reg <= sh_next;
            dout_reg <= dout_next;
            drv_reg <= drv_next;
            kh_reg <= kh_next;
        end
    end

    assign dout = dout_reg;
    assign dout_oen = ~drv_reg;
    assign keeper_on = (keeper_mode == KEEP_ON) || (kh_reg != 2'h0);

    // ============================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_lsb_half;
        (run && !frame_start && st_reg == L_SHIFT && bits_reg == 5'h00 && bclk_rise && lsb_half) |=> dout_oen;
    endproperty
    a_lsb_half: assert property (p_lsb_half) else $error("last bit not released at half period");

    property p_keeper_load;
        (kh_next == KH_ONE_HALF && kh_reg == 2'h0) |=> keeper_on [*1] ##0 (kh_reg == KH_ONE_HALF);
    endproperty
    a_keeper_load: assert property (p_keeper_load) else $error("keeper not on for last bit");

    property p_delay_load;
        (run && frame_start) |=> (st_reg == L_WAIT) && (dly_reg == 6'(offset) + 6'(lead));
    endproperty
    a_delay_load: assert property (p_delay_load) else $error("start delay not loaded");
endmodule

// *** hw/asi_tx_pkg.sv ***
// constants shared by the audio serial transmit output control block
package asi_tx_pkg;
    // ============================================================
    // widths
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int WORD_BITS = 32;
    localparam int LEN_W = 10;
    localparam int STAT_W = 3;
    // ============================================================
    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_CFG1 = 6'h08;
    localparam logic [5:0] IDX_CFG2 = 6'h09;
    localparam logic [5:0] IDX_MIX = 6'h0A;
    localparam logic [5:0] IDX_STAT = 6'h10;
    localparam logic [5:0] IDX_MASK = 6'h11;
    localparam logic [5:0] IDX_STATE = 6'h12;
    // ============================================================
    // reset values and writable bits
    localparam logic [7:0] CFG1_RST = 8'h00;
    localparam logic [7:0] CFG2_RST = 8'h00;
    localparam logic [7:0] MIX_RST = 8'h00;
    localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
    localparam logic [STAT_W-1:0] MASK_RST = 3'h0;
    localparam logic [7:0] CFG1_WMASK = 8'hFF;
    localparam logic [7:0] CFG2_WMASK = 8'hB8;
    localparam logic [7:0] MIX_WMASK = 8'hF8;
    // ============================================================
    // field positions
    localparam int LSB_HALF_BIT = 7;
    localparam int KEEP_HI = 6;
    localparam int KEEP_LO = 5;
    localparam int OFS_HI = 4;
    localparam int DAISY_BIT = 7;
    localparam int ERR_OFF_BIT = 5;
    localparam int RESUME_OFF_BIT = 4;
    localparam int MIX_HI = 7;
    localparam int MIX_LO = 6;
    localparam int ST_ERR = 0;
    localparam int ST_RESUME = 1;
    localparam int ST_DAISY_REJ = 2;
    // ============================================================
    // encodings
    localparam logic [1:0] KEEP_OFF = 2'h0;
    localparam logic [1:0] KEEP_ON = 2'h1;
    localparam logic [1:0] KEEP_LSB1 = 2'h2;
    localparam logic [1:0] KEEP_LSB15 = 2'h3;
    localparam logic [1:0] KH_ONE = 2'h2;
    localparam logic [1:0] KH_ONE_HALF = 2'h3;
    localparam logic [1:0] FMT_TDM = 2'h0;
    localparam logic [1:0] FMT_I2S = 2'h1;
    localparam logic [1:0] MIX_NONE = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** tb/link_model.sv ***
// host side of the serial link: bit clock and frame sync
`timescale 1ns/1ps
module link_model (
    // control
    input wire logic run,
    input wire logic [7:0] frame_len,
    // link
    output logic bclk,
    output logic fsync
);
    int n;
    initial begin
        bclk = 1'b0;
        fsync = 1'b0;
        wait (run === 1'b1);
        #1;
        forever begin
            for (n = 0; n < frame_len; n++) begin
                fsync = (n == 0);
                #80 bclk = 1'b1;
                #80 bclk = 1'b0;
            end
        end
    end
endmodule

// *** tb/tb.sv ***
// testbench for the audio serial transmit output control block
`timescale 1ns/1ps
module tb
    import asi_tx_pkg::*;
();
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run;
    logic awready, wready, bvalid, arready, rvalid, bclk, fsync;
    logic pri_dout, pri_dout_oen, pri_keeper_en, sec_dout, sec_dout_oen, sec_keeper_en;
    logic daisy_chain, rec_power_on, irq;
    logic [7:0] awaddr, araddr, flen;
    logic [31:0] wdata, rdata, rv;
    logic [1:0] bresp, rresp, rs;
    int mismatches, total_checks;
    asi_tx_ctrl uut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .bclk(bclk), .fsync(fsync), .asi_format(FMT_TDM),
        .tx_word_pri(32'hA5C30F96), .tx_word_sec(32'hA5C30F96), .pri_dout(pri_dout),
        .pri_dout_oen(pri_dout_oen), .pri_keeper_en(pri_keeper_en), .sec_dout(sec_dout),
        .sec_dout_oen(sec_dout_oen), .sec_keeper_en(sec_keeper_en), .daisy_chain(daisy_chain),
        .rec_power_on(rec_power_on), .irq(irq)
    );
    link_model lm (.run(run), .frame_len(flen), .bclk(bclk), .fsync(fsync));
    // ========================================
    // helpers
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh, bh;
        int i;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(negedge aclk);
            ah = awready & awvalid;
            wh = wready & wvalid;
            bh = bvalid;
            @(posedge aclk);
            if (ah === 1'b1) awvalid <= 1'b0;
            if (wh === 1'b1) wvalid <= 1'b0;
            if (bh === 1'b1) break;
        end
        bready <= 1'b0;
        @(posedge aclk);
        if (i == 40) begin
            mismatches++;
            conclude;
        end
    endtask
    task automatic rd(input logic [7:0] a);
        logic ah, rh;
        int i;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(negedge aclk);
            ah = arready & arvalid;
            rh = rvalid;
            rv = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ah === 1'b1) arvalid <= 1'b0;
            if (rh === 1'b1) break;
        end
        rready <= 1'b0;
        @(posedge aclk);
        if (i == 40) begin
            mismatches++;
            conclude;
        end
    endtask
    // ========================================
    // scenarios
    task automatic t_regs;
        rd(8'h20);
        chk("cfg1", rv, 32'h0);
        rd(8'hFC);
        chk("unmapped", rs, RESP_SLVERR);
        wr(8'h24, 32'hB8);
        rd(8'h24);
        chk("cfg2", rv, 32'hB8);
        chk("chain", daisy_chain, 1'b1);
        wr(8'h28, 32'h40);
        rd(8'h40);
        chk("mix reject", rv[2], 1'b1);
        wr(8'h28, 32'h00);
        wr(8'h24, 32'h00);
        chk("shared", daisy_chain, 1'b0);
    endtask
    task automatic t_link;
        int i, bad, drv;
        wr(8'h44, 32'h01);
        run <= 1'b1;
        bad = 0;
        drv = 0;
        for (i = 0; i < 12000; i++) begin
            @(negedge aclk);
            if (pri_dout_oen === 1'b0) drv++;
            if ({pri_dout, pri_dout_oen, pri_keeper_en} !== {sec_dout, sec_dout_oen, sec_keeper_en}) bad++;
        end
        chk("lanes", bad, 0);
        chk("driven", drv > 0, 1'b1);
        chk("no error", rec_power_on, 1'b1);
        wr(8'h40, 32'h07);
        flen <= 8'h30;
        for (i = 0; i < 9000 && rec_power_on !== 1'b0; i++) @(negedge aclk);
        if (i == 9000) begin
            mismatches++;
            conclude;
        end
        chk("halt", rec_power_on, 1'b0);
        chk("irq", irq, 1'b1);
        flen <= 8'h40;
        for (i = 0; i < 20000 && rec_power_on !== 1'b1; i++) @(negedge aclk);
        if (i == 20000) begin
            mismatches++;
            conclude;
        end
        chk("resume", rec_power_on, 1'b1);
        wr(8'h40, 32'h07);
        chk("irq clear", irq, 1'b0);
    endtask
    task automatic t_keep;
        int i, dc, kc;
        logic [31:0] w;
        wr(8'h20, 32'hE0);
        for (i = 0; i < 6000 && pri_dout_oen !== 1'b1; i++) @(negedge aclk);
        for (i = 0; i < 6000 && pri_dout_oen !== 1'b0; i++) @(negedge aclk);
        dc = 0;
        kc = 0;
        w = '0;
        for (i = 0; i < 1400; i++) begin
            if (pri_dout_oen === 1'b0) dc++;
            if (pri_keeper_en === 1'b1) kc++;
            if (i % 40 == 10 && i < 1280) w = {w[30:0], pri_dout};
            @(negedge aclk);
        end
        chk("lsb half", dc, 1260);
        chk("keeper", kc, 60);
        chk("word", w, 32'hA5C30F96);
    endtask
    // ========================================
    // clock and main sequence
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, run} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        flen = 8'h40;
        mismatches = 0;
        total_checks = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs;
        t_link;
        t_keep;
        conclude;
    end
endmodule
